// >>> shared/booth_pkg.sv
package booth_pkg;

  localparam int WORD_W = 8;
  localparam int PROD_W = 2 * WORD_W;
  localparam int SIGN_IDX = WORD_W - 1;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 5;

  // clock period and the figures of one multiplication, in clock periods
  localparam real CLOCK_PERIOD_NS = 4.0;
  localparam int TOTAL_PERIODS = 18;
  localparam int LOAD_PERIODS = 1;
  localparam logic [CNT_W-1:0] FIRST_SAMPLE = 5'h01;
  localparam logic [CNT_W-1:0] LAST_SAMPLE = 5'(TOTAL_PERIODS - LOAD_PERIODS - 1);

  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  localparam logic [PROD_W-1:0] PROD_RESET = 16'h0000;

  // booth action codes shown on the slice's status port
  localparam logic [1:0] ACT_SHIFT = 2'h0;
  localparam logic [1:0] ACT_ADD = 2'h1;
  localparam logic [1:0] ACT_SUB = 2'h2;

  typedef enum logic [3:0] {
    SRC_IDLE = 4'b0001,
    SRC_LOAD = 4'b0010,
    SRC_RUN = 4'b0100,
    SRC_PUSH = 4'b1000
  } src_state_t;

  // two-bit sum of three bits
  function automatic logic [1:0] full_add(input logic a, input logic b, input logic c);
    full_add = {1'b0, a} + {1'b0, b} + {1'b0, c};
  endfunction : full_add

  // multiplier bit for a period, the sign bit repeated past the top
  function automatic logic pick_bit(input logic [WORD_W-1:0] w, input logic [CNT_W-1:0] idx);
    pick_bit = (idx > 5'(SIGN_IDX)) ? w[SIGN_IDX] : w[idx[2:0]];
  endfunction : pick_bit

endpackage : booth_pkg

// >>> shared/booth_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface booth_link_if;
  logic [7:0] multiplicand_in;
  logic async_master_clear_n;
  logic serial_multiplier;
  logic serial_expansion;
  logic mode_control;
  logic serial_product;

  modport slice (
    input multiplicand_in,
    input async_master_clear_n,
    input serial_multiplier,
    input serial_expansion,
    input mode_control,
    output serial_product
  );

  modport source (
    output multiplicand_in,
    output async_master_clear_n,
    output serial_multiplier,
    output serial_expansion,
    output mode_control,
    input serial_product
  );
endinterface : booth_link_if
`default_nettype wire

// >>> rtl/booth_slice.sv
// Summary of operation
// - booth recoded twos complement serial multiply
// - eight-bit multiplicand held through the multiplication
// - source sends multiplier bits lsb first
// - product shifted out lsb first, one per clock
// - state changes on rising clock edge, or at once when clear falls
// - clear low resets arithmetic flops without clock edge
// - latches follow inputs while clear low
// - clear empties previous bit, carries, sums
// - clear low forces product and previous bit low
// - bit pair picks shift, add or subtract
// - top slice holds mode and expansion low
// - lower slices: mode high, expansion from above
// - expansion feeds top cell when mode high, else own top sum
// - per-cell carry flops, carry-save form
// - multiplier bit registered into lsb next edge
// - each period emits term one cell upstream
// - source repeats sign bit eight more periods
// - controller pulses clear over load period
// - eight by eight takes eighteen periods
// - wide multiplicands sign-extended on top slice
`timescale 1ns/1ps
`default_nettype none
module booth_slice
  import booth_pkg::*;
(
  input wire logic clock,                  // rising edge clock
  input wire logic reset,                  // synchronous, active high
  booth_link_if.slice link,                // serial link to the source
  output logic previous_multiplier_bit,    // delayed multiplier bit
  output logic latch_transparent,          // multiplicand latches open
  output logic [1:0] booth_result_bit      // action taken at the last edge
);

  logic [WORD_W-1:0] held_reg;
  logic [WORD_W-1:0] sum_reg;
  logic [WORD_W-1:0] sum_next;
  logic [WORD_W-1:1] carry_reg;
  logic [WORD_W-1:1] carry_next;
  logic [1:0] low_carry_reg;
  logic [1:0] low_carry_next;
  logic prev_reg;
  logic open_reg;
  logic [1:0] action_reg;

  wire logic cur_bit;
  wire logic do_add;
  wire logic do_sub;
  wire logic [1:0] action_next;
  wire logic [WORD_W-1:0] addend;
  wire logic [WORD_W-1:0] upstream;
  wire logic [2:0] low_total;

  assign cur_bit = link.serial_multiplier;
  assign do_add = !cur_bit && prev_reg;
  assign do_sub = cur_bit && !prev_reg;
  assign action_next = do_add ? ACT_ADD : (do_sub ? ACT_SUB : ACT_SHIFT);

  // subtract adds the inverted multiplicand; its +1 enters at the lsb cell
  assign addend = (do_add || do_sub) ? (held_reg ^ {WORD_W{do_sub}}) : WORD_RESET;

  // each cell takes the partial sum of the cell above it
  assign upstream[WORD_W-2:0] = sum_reg[WORD_W-1:1];
  // top cell: expansion in cascade, own sum held as sign in the top slice
  assign upstream[WORD_W-1] = link.mode_control ? link.serial_expansion
                                                : sum_reg[WORD_W-1];

  // lsb cell adds four terms, so its carry store is two bits wide
  assign low_total = {2'h0, upstream[0]} + {2'h0, addend[0]} + {1'b0, low_carry_reg}
                   + {2'h0, do_sub};

  always_comb begin
    sum_next[0] = low_total[0];
    low_carry_next = low_total[2:1];
    for (int i = 1; i < WORD_W; i++) begin
      {carry_next[i], sum_next[i]} = full_add(upstream[i], addend[i], carry_reg[i]);
    end
  end

  // arithmetic flops, cleared at once by the master clear
  always_ff @(posedge clock or negedge link.async_master_clear_n) begin
    if (!link.async_master_clear_n) begin
      sum_reg <= WORD_RESET;
      carry_reg <= '0;
      low_carry_reg <= 2'h0;
      prev_reg <= 1'b0;
      open_reg <= 1'b1;
      action_reg <= ACT_SHIFT;
    end else if (reset) begin
      sum_reg <= WORD_RESET;
      carry_reg <= '0;
      low_carry_reg <= 2'h0;
      prev_reg <= 1'b0;
      open_reg <= 1'b0;
      action_reg <= ACT_SHIFT;
    end else begin
      sum_reg <= sum_next;
      carry_reg <= carry_next;
      low_carry_reg <= low_carry_next;
      prev_reg <= cur_bit;
      open_reg <= 1'b0;
      action_reg <= action_next;
    end
  end

  // multiplicand follows the inputs while clear is low, kept once it rises
  always_ff @(posedge clock) begin
    if (reset) begin
      held_reg <= WORD_RESET;
    end else if (!link.async_master_clear_n) begin
      held_reg <= link.multiplicand_in;
    end
  end

  assign link.serial_product = sum_reg[0];
  assign previous_multiplier_bit = prev_reg;
  assign latch_transparent = open_reg;
  assign booth_result_bit = action_reg;

endmodule : booth_slice
`default_nettype wire

// >>> rtl/booth_source.sv
`timescale 1ns/1ps
`default_nettype none
module booth_product_fifo
  import booth_pkg::*;
#(
  parameter int WIDTH = PROD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,                  // rising edge clock
  input wire logic reset,                  // synchronous, active high
  input wire logic in_valid,               // word offered
  output logic in_ready,                   // room for a word
  input wire logic [WIDTH-1:0] in_data,    // word in
  output logic out_valid,                  // word available
  input wire logic out_ready,              // consumer takes word
  output logic [WIDTH-1:0] out_data        // word out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire logic full;
  wire logic empty;
  wire logic do_write;
  wire logic do_load;

  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign do_write = in_valid && !full;
  assign do_load = !empty && (!out_valid_reg || out_ready);

  always_ff @(posedge clock) begin
    if (do_write) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      if (do_write) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_load) begin
        rd_reg <= rd_reg + 1'b1;
        out_data_reg <= mem[rd_reg[AW-1:0]];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign in_ready = !full;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
endmodule : booth_product_fifo

module booth_source
  import booth_pkg::*;
(
  input wire logic clock,                      // rising edge clock
  input wire logic reset,                      // synchronous, active high
  input wire logic start_valid,                // operands offered
  output logic start_ready,                    // operands accepted when high
  input wire logic [WORD_W-1:0] start_multiplicand, // multiplicand word
  input wire logic [WORD_W-1:0] start_multiplier,   // multiplier word
  output logic product_valid,                  // product word available
  input wire logic product_ready,              // consumer takes product
  output logic [PROD_W-1:0] product_data,      // sixteen-bit product
  booth_link_if.source link                    // serial link to the slice
);

  src_state_t state_reg;
  src_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [WORD_W-1:0] mult_reg;
  logic [WORD_W-1:0] x_reg;
  logic [PROD_W-1:0] prod_reg;
  logic clear_n_reg;
  logic y_reg;
  logic ready_reg;

  wire logic fifo_in_ready;
  wire logic push_valid;
  wire logic sampling;
  wire logic [PROD_W-1:0] prod_shifted;
  wire logic [CNT_W-1:0] cnt_inc;

  assign push_valid = (state_reg == SRC_PUSH);
  assign sampling = (state_reg == SRC_RUN) && (cnt_reg >= FIRST_SAMPLE);
  assign prod_shifted = {link.serial_product, prod_reg[PROD_W-1:1]};
  assign cnt_inc = cnt_reg + 1'b1;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRC_IDLE: begin
        if (start_valid && ready_reg) begin
          state_next = SRC_LOAD;
        end
      end
      SRC_LOAD: begin
        state_next = SRC_RUN;
      end
      SRC_RUN: begin
        if (cnt_reg == LAST_SAMPLE) begin
          state_next = SRC_PUSH;
        end
      end
      SRC_PUSH: begin
        if (fifo_in_ready) begin
          state_next = SRC_IDLE;
        end
      end
      default: begin
        state_next = SRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= SRC_IDLE;
      cnt_reg <= '0;
      mult_reg <= WORD_RESET;
      x_reg <= WORD_RESET;
      prod_reg <= PROD_RESET;
      clear_n_reg <= 1'b1;
      y_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // refuse new operands while the buffer has no room; the full flag settles after a push
      ready_reg <= (state_next == SRC_IDLE) && fifo_in_ready && !push_valid;
      if (state_next == SRC_LOAD) begin
        clear_n_reg <= 1'b0;
        x_reg <= start_multiplicand;
        mult_reg <= start_multiplier;
      end
      if (state_reg == SRC_LOAD) begin
        clear_n_reg <= 1'b1;
        y_reg <= pick_bit(mult_reg, '0);
        cnt_reg <= '0;
      end
      if (state_reg == SRC_RUN) begin
        cnt_reg <= cnt_inc;
        y_reg <= pick_bit(mult_reg, cnt_inc);
      end
      if (sampling) begin
        prod_reg <= prod_shifted;
      end
    end
  end

  booth_product_fifo #(
    .WIDTH(PROD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(prod_reg),
    .out_valid(product_valid),
    .out_ready(product_ready),
    .out_data(product_data)
  );

  // one slice covers the whole multiplicand, so no upper inputs need the sign copied
  assign link.multiplicand_in = x_reg;
  assign link.async_master_clear_n = clear_n_reg;
  assign link.serial_multiplier = y_reg;
  // a single slice is the most significant one
  assign link.serial_expansion = 1'b0;
  assign link.mode_control = 1'b0;
  assign start_ready = ready_reg;
endmodule : booth_source
`default_nettype wire

// >>> verif/booth_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module booth_link_properties
  import booth_pkg::*;
(
  input wire logic clock,                    // rising edge clock
  input wire logic reset,                    // synchronous, active high
  input wire logic async_master_clear_n,     // clear from the source
  input wire logic serial_multiplier,        // multiplier bit stream
  input wire logic serial_expansion,         // expansion input
  input wire logic mode_control,             // mode input
  input wire logic serial_product,           // product bit stream
  input wire logic previous_multiplier_bit,  // delayed multiplier bit
  input wire logic latch_transparent,        // multiplicand latches open
  input wire logic [1:0] booth_result_bit    // action at the last edge
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence clear_pulse;
    $fell(async_master_clear_n);
  endsequence

  sequence run_held;
    async_master_clear_n ##1 async_master_clear_n;
  endsequence

  clear_forces_low_a: assert property (
    !async_master_clear_n |-> !serial_product && !previous_multiplier_bit)
    else $error("product or previous bit high while clear is low");
  latch_open_a: assert property (!async_master_clear_n |-> latch_transparent)
    else $error("latches closed while clear is low");
  latch_close_a: assert property ($rose(async_master_clear_n) |=> !latch_transparent)
    else $error("latches still open after clear release");
  prev_bit_follows_a: assert property (
    run_held |-> previous_multiplier_bit == $past(serial_multiplier))
    else $error("previous bit does not follow the multiplier input");
  booth_action_a: assert property (run_held |-> booth_result_bit ==
    (($past(serial_multiplier) == $past(previous_multiplier_bit)) ? ACT_SHIFT :
    ($past(serial_multiplier) ? ACT_SUB : ACT_ADD)))
    else $error("wrong action for the multiplier bit pair");
  top_mode_low_a: assert property (!mode_control && !serial_expansion)
    else $error("mode or expansion high on the top slice");
  run_length_a: assert property (clear_pulse |=>
    async_master_clear_n[*8] ##1 async_master_clear_n[*8] ##1 async_master_clear_n)
    else $error("clear reasserted before the run ended");
  sign_repeat_a: assert property (clear_pulse |-> ##9 $stable(serial_multiplier)[*8])
    else $error("sign bit not repeated");
endmodule : booth_link_properties
`default_nettype wire

// >>> verif/test_serial_parallel_booth_multiplier.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_parallel_booth_multiplier;
  import booth_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic start_valid = 1'b0;
  logic product_ready = 1'b1;
  logic [WORD_W-1:0] start_multiplicand = 8'h00;
  logic [WORD_W-1:0] start_multiplier = 8'h00;
  logic start_ready, product_valid, previous_multiplier_bit, latch_transparent;
  logic [PROD_W-1:0] product_data;
  logic [1:0] booth_result_bit;
  logic [PROD_W-1:0] expect_q[$];
  logic [15:0] ops [8] = '{16'h0000, 16'h7f7f, 16'h8080, 16'h807f,
                           16'hff01, 16'h01ff, 16'h55aa, 16'hc33c};
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  booth_link_if link_bus();
  booth_slice i_booth_slice (.clock(clock), .reset(reset), .link(link_bus),
    .previous_multiplier_bit(previous_multiplier_bit),
    .latch_transparent(latch_transparent), .booth_result_bit(booth_result_bit));
  booth_source i_booth_source (.clock(clock), .reset(reset), .start_valid(start_valid),
    .start_ready(start_ready), .start_multiplicand(start_multiplicand),
    .start_multiplier(start_multiplier), .product_valid(product_valid),
    .product_ready(product_ready), .product_data(product_data), .link(link_bus));
  booth_link_properties props (.clock(clock), .reset(reset),
    .async_master_clear_n(link_bus.async_master_clear_n),
    .serial_multiplier(link_bus.serial_multiplier),
    .serial_expansion(link_bus.serial_expansion), .mode_control(link_bus.mode_control),
    .serial_product(link_bus.serial_product),
    .previous_multiplier_bit(previous_multiplier_bit),
    .latch_transparent(latch_transparent), .booth_result_bit(booth_result_bit));

  always #2 clock = ~clock;

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // the whole run needs about 960 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      results();
    end
  end

  task automatic check_word(input logic [PROD_W-1:0] got, input logic [PROD_W-1:0] exp,
                            input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_flag

  // hand over one operand pair and collect the serial product, lsb first
  task automatic multiply(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    logic [PROD_W-1:0] exp;
    logic [PROD_W-1:0] bits;
    exp = $signed(a) * $signed(b);
    @(posedge clock);
    start_valid <= 1'b1;
    start_multiplicand <= a;
    start_multiplier <= b;
    do @(negedge clock); while (start_ready !== 1'b1);
    @(posedge clock);
    start_valid <= 1'b0;
    expect_q.push_back(exp);
    repeat (2) @(posedge clock);
    for (int j = 0; j < PROD_W; j++) begin
      @(negedge clock);
      bits[j] = link_bus.serial_product;
      @(posedge clock);
    end
    check_word(bits, exp, "serial product");
  endtask : multiply

  task automatic take_product();
    do @(negedge clock); while (product_valid !== 1'b1);
    check_word(product_data, expect_q.pop_front(), "product word");
    @(posedge clock);
  endtask : take_product

  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check_flag(link_bus.serial_product, 1'b0, "idle product line");
    foreach (ops[i]) begin
      multiply(ops[i][15:8], ops[i][7:0]);
      take_product();
    end
    $display("corner operand test done");
    product_ready <= 1'b0;
    for (int i = 0; i < 33; i++) begin
      multiply(8'(i * 37 + 5), 8'(i * 91 + 200));
    end
    repeat (40) @(negedge clock);
    check_flag(start_ready, 1'b0, "start refused while full");
    check_flag(product_valid, 1'b1, "product waiting while stalled");
    @(posedge clock);
    product_ready <= 1'b1;
    repeat (33) take_product();
    @(negedge clock);
    check_flag(product_valid, 1'b0, "buffer empty after drain");
    $display("fill and drain test done");
    results();
  end
endmodule : test_serial_parallel_booth_multiplier
`default_nettype wire
